/* rtl/atssr_top.v */
// shadow status, drive select, command latch and shadow drive control bank
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "atssr_map.vh"
module atssr_top
#(
  parameter ADDR_W = 8
)
(
  input  wire              clk,                     // system clock, 125 MHz
  input  wire              rst,                     // chip reset, active high
  input  wire              psel,                    // apb select
  input  wire              penable,                 // apb enable
  input  wire              pwrite,                  // apb direction
  input  wire [ADDR_W-1:0] paddr,                   // apb byte address
  input  wire [31:0]       pwdata,                  // apb write data
  output reg  [31:0]       prdata,                  // apb read data
  output reg               pready,                  // apb ready
  output reg               pslverr,                 // apb error, unmapped
  input  wire              host_reset,              // host reset level
  input  wire              soft_reset,              // soft reset level
  input  wire              firmware_reset,          // firmware reset level
  input  wire              host_cmd_wr,             // host command write pulse
  input  wire [7:0]        host_cmd_data,           // host opcode
  input  wire              host_dsel_wr,            // host drive select write pulse
  input  wire [7:0]        host_dsel_data,          // host drive select data
  input  wire              auto_packet_active,      // automatic packet transfer
  input  wire              auto_status_active,      // automatic status completion
  input  wire              master_drive_config,     // drive strapped as master
  input  wire              drive_active_pin,        // drive active pin level
  output reg  [7:0]        host_status_q,           // host visible status
  output reg  [7:0]        host_drive_select_q,     // drive select to host
  output reg  [7:0]        host_shadow_status_q,    // shadow status to host
  output reg  [7:0]        host_shadow_error_q,     // shadow error to host
  output reg               shadow_drive_enable_q,   // shadow emulation on
  output reg               drive_active_out_enable_q // drive active output enable
);

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire [ADDR_W-3:0] idx = paddr[ADDR_W-1:2];
  wire              acc = psel & penable & pready;
  wire              wr  = acc & pwrite;
  wire [7:0]        wd  = pwdata[7:0];

  wire sel_dsel = (idx == `ATSSR_IDX_DRIVE_SELECT);
  wire sel_sc   = (idx == `ATSSR_IDX_STATUS_CMD);
  wire sel_ss   = (idx == `ATSSR_IDX_STATUS_SHADOW);
  wire sel_se   = (idx == `ATSSR_IDX_SHADOW_ERROR);
  wire sel_fc   = (idx == `ATSSR_IDX_FW_CONTROL);
  wire sel_pk   = (idx == `ATSSR_IDX_PACKET_STATUS);
  wire sel_cs   = (idx == `ATSSR_IDX_COMPL_STATUS);
  wire sel_sd   = (idx == `ATSSR_IDX_SHADOW_CTL);
  wire mapped   = sel_dsel | sel_sc | sel_ss | sel_se | sel_fc | sel_pk
                | sel_cs | sel_sd;

  wire wr_dsel = wr & sel_dsel;
  wire wr_sta  = wr & sel_sc;
  wire wr_ss   = wr & sel_ss;
  wire wr_se   = wr & sel_se;
  wire wr_fc   = wr & sel_fc;
  wire wr_pk   = wr & sel_pk;
  wire wr_cs   = wr & sel_cs;
  wire wr_sd   = wr & sel_sd;

  // ------------------------------------------------------------
  // event decode
  // ------------------------------------------------------------
  wire hard_rst = rst | host_reset;
  wire diag_cmd = host_cmd_wr & (host_cmd_data == `ATSSR_OPC_DIAG);
  wire sig_init = wr_fc & wd[`ATSSR_FWC_SIG_INIT];
  wire fw_clr   = wr_fc & wd[`ATSSR_FWC_CLR_BSY];
  wire fw_set   = wr_fc & wd[`ATSSR_FWC_SET_BSY];
  wire hrst_end;
  wire srst_end;

  atssr_fall_det u_hrst_end
  (
    .clk   (clk),
    .rst   (rst),
    .level (host_reset),
    .fall  (hrst_end)
  );

  atssr_fall_det u_srst_end
  (
    .clk   (clk),
    .rst   (rst),
    .level (soft_reset),
    .fall  (srst_end)
  );

  // ------------------------------------------------------------
  // drive select
  // ------------------------------------------------------------
  reg [7:0] drive_select_q;
  reg [7:0] drive_select_d;

  always @*
  begin
    drive_select_d = drive_select_q;
    if (hard_rst || soft_reset || diag_cmd)
      drive_select_d = `ATSSR_RST_DRIVE_SELECT;
    else if (host_dsel_wr)
      drive_select_d = host_dsel_data;
    else if (wr_dsel)
      drive_select_d = wd;
    // signature init absent from the load terms
  end

  always @(posedge clk)
  begin
    if (rst)
      drive_select_q <= `ATSSR_RST_DRIVE_SELECT;
    else
      drive_select_q <= drive_select_d;
  end

  // ------------------------------------------------------------
  // command latch
  // ------------------------------------------------------------
  reg [7:0] command_latch_q;

  always @(posedge clk)
  begin
    if (host_cmd_wr)
      command_latch_q <= host_cmd_data;
  end

  // ------------------------------------------------------------
  // host status
  // ------------------------------------------------------------
  reg [7:0] status_q;
  reg [7:0] status_d;

  always @*
  begin
    status_d = status_q;
    if (hard_rst)
      // all but msb cleared, busy raised
      status_d = `ATSSR_RST_STATUS_HARD;
    else if (soft_reset || diag_cmd)
    begin
      // keep bit 4, busy raised by the reset
      status_d = {1'b1, 2'b00, status_q[`ATSSR_STA_DSC], 4'h0};
    end
    else if (sig_init)
    begin
      status_d = {status_q[`ATSSR_STA_BSY], 2'b00, status_q[`ATSSR_STA_DSC], 4'h0};
    end
    else
    begin
      if (wr_sta)
        status_d[6:0] = wd[6:0];
      // busy set wins over clear
      if (host_cmd_wr || fw_set)
        status_d[`ATSSR_STA_BSY] = 1'b1;
      else if (fw_clr)
        status_d[`ATSSR_STA_BSY] = 1'b0;
      // firmware reset clears corr and check
      if (firmware_reset)
      begin
        status_d[`ATSSR_STA_CORR]  = 1'b0;
        status_d[`ATSSR_STA_CHECK] = 1'b0;
      end
    end
  end

  always @(posedge clk)
  begin
    if (rst)
      status_q <= `ATSSR_RST_STATUS_HARD;
    else
      status_q <= status_d;
  end

  // ------------------------------------------------------------
  // automatic status sources
  // ------------------------------------------------------------
  wire [7:0] packet_status;
  wire [7:0] compl_status;
  wire [7:0] shadow_error;

  atssr_byte_reg u_packet_status
  (
    .clk     (clk),
    .rst     (rst),
    .clr     (host_reset),
    .we      (wr_pk),
    .wdata   (wd),
    .value_q (packet_status)
  );

  // completion bits cleared by chip, host, firmware reset
  atssr_byte_reg u_compl_status
  (
    .clk     (clk),
    .rst     (rst),
    .clr     (host_reset | firmware_reset),
    .we      (wr_cs),
    .wdata   (wd),
    .value_q (compl_status)
  );

  atssr_byte_reg
  #(
    .WMASK (8'h04),
    .RSTV  (`ATSSR_RST_ZERO)
  )
  u_shadow_error
  (
    .clk     (clk),
    .rst     (rst),
    .clr     (host_reset),
    .we      (wr_se),
    .wdata   (wd),
    .value_q (shadow_error)
  );

  reg [7:0] host_view;

  always @*
  begin
    host_view = status_q;
    if (auto_packet_active)
      host_view[`ATSSR_STA_DSC] = packet_status[`ATSSR_STA_DSC];
    if (auto_status_active)
    begin
      host_view[`ATSSR_STA_DRDY] = compl_status[`ATSSR_STA_DRDY];
      host_view[`ATSSR_STA_CORR]  = compl_status[`ATSSR_STA_CORR];
      host_view[`ATSSR_STA_CHECK] = compl_status[`ATSSR_STA_CHECK];
    end
  end

  // ------------------------------------------------------------
  // shadow check bit
  // ------------------------------------------------------------
  reg shadow_check_q;

  always @(posedge clk)
  begin
    // cleared by chip or host reset and by each command write without a same cycle firmware write
    if (hard_rst)
      shadow_check_q <= 1'b0;
    else if (wr_ss)
      // firmware set wins over a same cycle command write
      shadow_check_q <= wd[`ATSSR_SHS_CHECK];
    else if (host_cmd_wr)
      shadow_check_q <= 1'b0;
  end

  // ------------------------------------------------------------
  // shadow drive control
  // ------------------------------------------------------------
  wire [7:0] sdc_sel;
  reg        shadow_enable_q;
  reg        after_hrst_q;
  reg        after_srst_q;

  // only latch and select bits are writable
  // latch cleared by chip or host reset
  atssr_byte_reg
  #(
    .WMASK (`ATSSR_SDC_WMASK),
    .RSTV  (`ATSSR_RST_ZERO)
  )
  u_shadow_ctl
  (
    .clk     (clk),
    .rst     (rst),
    .clr     (1'b0),
    .we      (wr_sd | host_reset),
    .wdata   (host_reset ? (sdc_sel & 8'h06) : wd),
    .value_q (sdc_sel)
  );

  always @(posedge clk)
  begin
    if (rst)
      shadow_enable_q <= 1'b0;
    else if (master_drive_config && !sdc_sel[`ATSSR_SDC_LATCH])
      shadow_enable_q <= drive_active_pin;
  end

  always @(posedge clk)
  begin
    if (rst || host_reset)
    begin
      after_hrst_q <= 1'b0;
      after_srst_q <= 1'b0;
    end
    else
    begin
      if (hrst_end)
        after_hrst_q <= 1'b1;
      if (soft_reset)
        after_srst_q <= 1'b0;
      else if (srst_end)
        after_srst_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // host side outputs
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      host_status_q             <= `ATSSR_RST_STATUS_HARD;
      host_drive_select_q       <= `ATSSR_RST_DRIVE_SELECT;
      host_shadow_status_q      <= `ATSSR_RST_STATUS_HARD;
      host_shadow_error_q       <= `ATSSR_RST_ZERO;
      shadow_drive_enable_q     <= 1'b0;
      drive_active_out_enable_q <= 1'b0;
    end
    else
    begin
      host_status_q        <= host_view;
      host_drive_select_q  <= drive_select_q;
      host_shadow_status_q <= {status_q[`ATSSR_STA_BSY], 6'h00, shadow_check_q};
      host_shadow_error_q  <= shadow_error;
      shadow_drive_enable_q <= shadow_enable_q;
      // during host reset; after host reset; after soft reset
      drive_active_out_enable_q <=
          (sdc_sel[`ATSSR_SDC_SEL_DURH] & host_reset)
        | (sdc_sel[`ATSSR_SDC_SEL_AFTH] & after_hrst_q)
        | (sdc_sel[`ATSSR_SDC_SEL_AFTS] & after_srst_q);
    end
  end

  // ------------------------------------------------------------
  // apb read and handshake
  // ------------------------------------------------------------
  reg [7:0] rd_byte;

  always @*
  begin
    rd_byte = 8'h00;
    case (1'b1)
      sel_dsel: rd_byte = drive_select_q;
      sel_sc:   rd_byte = command_latch_q;
      sel_ss:   rd_byte = host_view;
      sel_se:   rd_byte = shadow_error;
      sel_fc:   rd_byte = {3'b000, auto_status_active, auto_packet_active,
                           master_drive_config, after_hrst_q, after_srst_q};
      sel_pk:   rd_byte = packet_status;
      sel_cs:   rd_byte = compl_status;
      sel_sd:   rd_byte = {1'b0, shadow_enable_q, sdc_sel[5], 2'b00, sdc_sel[2:0]};
      default:  rd_byte = 8'h00;
    endcase
  end

  // answer in the first access cycle, no wait states
  always @(posedge clk)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel && !penable && !pwrite)
        prdata <= {24'h00_0000, rd_byte};
    end
  end

endmodule
`default_nettype wire

/* rtl/atssr_map.vh */
// register indexes, bit positions, reset values and codes of the shadow status bank
`ifndef ATSSR_MAP_VH
`define ATSSR_MAP_VH

// register indexes (byte address is four times the index)
`define ATSSR_IDX_DRIVE_SELECT  6'h36
`define ATSSR_IDX_STATUS_CMD    6'h37
`define ATSSR_IDX_STATUS_SHADOW 6'h38
`define ATSSR_IDX_SHADOW_ERROR  6'h39
`define ATSSR_IDX_FW_CONTROL    6'h3c
`define ATSSR_IDX_PACKET_STATUS 6'h3d
`define ATSSR_IDX_COMPL_STATUS  6'h3e
`define ATSSR_IDX_SHADOW_CTL    6'h3f

// host status bit positions
`define ATSSR_STA_BSY   7
`define ATSSR_STA_DRDY  6
`define ATSSR_STA_DSC   4
`define ATSSR_STA_CORR  2
`define ATSSR_STA_CHECK 0

// shadow status / shadow error bit positions
`define ATSSR_SHS_CHECK 0
`define ATSSR_SHE_ABORT 2

// shadow drive control bit positions and writable mask
`define ATSSR_SDC_ENABLE   6
`define ATSSR_SDC_LATCH    5
`define ATSSR_SDC_SEL_DURH 2
`define ATSSR_SDC_SEL_AFTH 1
`define ATSSR_SDC_SEL_AFTS 0
`define ATSSR_SDC_WMASK    8'h27

// firmware control bit positions
`define ATSSR_FWC_CLR_BSY  0
`define ATSSR_FWC_SET_BSY  1
`define ATSSR_FWC_SIG_INIT 4

// reset values and codes
`define ATSSR_RST_DRIVE_SELECT 8'h00
`define ATSSR_RST_STATUS_HARD  8'h80
`define ATSSR_RST_ZERO         8'h00
`define ATSSR_OPC_DIAG         8'h90

`endif

/* rtl/atssr_byte_reg.v */
// byte register with write strobe, bit write mask and synchronous clear
`timescale 1ns/100ps
`default_nettype none
module atssr_byte_reg
#(
  parameter [7:0] WMASK = 8'hff,
  parameter [7:0] RSTV  = 8'h00
)
(
  input  wire       clk,    // system clock
  input  wire       rst,    // chip reset
  input  wire       clr,    // synchronous clear to reset value
  input  wire       we,     // write strobe
  input  wire [7:0] wdata,  // write data
  output reg  [7:0] value_q // stored value
);
  always @(posedge clk)
  begin
    if (rst || clr)
      value_q <= RSTV;
    else if (we)
      value_q <= (wdata & WMASK) | (value_q & ~WMASK);
  end
endmodule
`default_nettype wire

/* rtl/atssr_fall_det.v */
// falling edge detector for a reset level
`timescale 1ns/100ps
`default_nettype none
module atssr_fall_det
(
  input  wire clk,    // system clock
  input  wire rst,    // chip reset
  input  wire level,  // watched level
  output wire fall    // one cycle pulse after level drops
);
  reg level_q;

  always @(posedge clk)
  begin
    if (rst)
      level_q <= 1'b0;
    else
      level_q <= level;
  end

  assign fall = level_q & ~level;
endmodule
`default_nettype wire

/* verif/atssr_checker.sv */
// port assertions for the shadow status bank
`timescale 1ns/100ps
`default_nettype none
module atssr_checker
#(
  parameter ADDR_W = 8
)
(
  input wire logic              clk,                  // system clock
  input wire logic              rst,                  // chip reset
  input wire logic              psel,                 // apb select
  input wire logic              penable,              // apb enable
  input wire logic [ADDR_W-1:0] paddr,                // apb address
  input wire logic              pready,               // apb ready
  input wire logic              pslverr,              // apb error
  input wire logic              host_reset,           // host reset
  input wire logic              host_cmd_wr,          // command pulse
  input wire logic [7:0]        host_cmd_data,        // opcode
  input wire logic [7:0]        host_status_q,        // host status
  input wire logic [7:0]        host_drive_select_q,  // drive select
  input wire logic [7:0]        host_shadow_status_q, // shadow status
  input wire logic [7:0]        host_shadow_error_q   // shadow error
);
  logic [5:0] idx;
  logic       mapped;
  assign idx    = paddr[7:2];
  assign mapped = (idx >= 6'h36 && idx <= 6'h39) || idx >= 6'h3c;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // ----------------------------------------
  // host command sequences
  // ----------------------------------------
  sequence cmd_quiet;
    host_cmd_wr && !psel ##1 !psel;
  endsequence
  sequence diag_quiet;
    host_cmd_wr && host_cmd_data == 8'h90 && !psel ##1 !psel;
  endsequence
  chk_ready_first: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  chk_hard_status: assert property (disable iff (1'b0) rst |=>
    host_status_q[6:0] == 7'h00 && !host_shadow_status_q[0])
    else $error("status not cleared by chip reset");
  chk_host_clear: assert property (host_reset ##1 host_reset ##1 host_reset |->
    host_drive_select_q == 8'h00 && host_status_q[6:0] == 7'h00 && !host_shadow_status_q[0])
    else $error("host reset did not clear registers");
  chk_cmd_clear: assert property (cmd_quiet |=> !host_shadow_status_q[0])
    else $error("shadow check kept after command");
  chk_diag_load: assert property (diag_quiet |=> host_drive_select_q == 8'h00 &&
    host_status_q[7] && host_status_q[6:5] == 2'b00 && host_status_q[3:0] == 4'h0)
    else $error("diagnostics did not load registers");
  chk_shadow_fmt: assert property (host_shadow_status_q[6:1] == 6'h00)
    else $error("shadow status middle bits set");
  chk_error_fmt: assert property ((host_shadow_error_q & 8'hfb) == 8'h00)
    else $error("shadow error stray bits");
endmodule
bind atssr_top atssr_checker #(.ADDR_W(ADDR_W)) atssr_checker_inst (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .host_reset(host_reset), .host_cmd_wr(host_cmd_wr), .host_cmd_data(host_cmd_data),
  .host_status_q(host_status_q), .host_drive_select_q(host_drive_select_q),
  .host_shadow_status_q(host_shadow_status_q), .host_shadow_error_q(host_shadow_error_q));
`default_nettype wire

/* verif/atssr_host_model.sv */
// host adapter model driving command, drive select and reset lines
`timescale 1ns/100ps
`default_nettype none
module atssr_host_model
(
  input  wire logic       clk,       // system clock
  output var  logic       cmd_wr,    // command write pulse
  output var  logic [7:0] cmd_data,  // opcode
  output var  logic       dsel_wr,   // drive select write pulse
  output var  logic [7:0] dsel_data, // drive select data
  output var  logic       rst_host,  // host reset level
  output var  logic       rst_soft   // soft reset level
);
  initial
  begin
    cmd_wr = 1'b0;
    cmd_data = 8'h5a;
    dsel_wr = 1'b0;
    dsel_data = 8'ha5;
    rst_host = 1'b0;
    rst_soft = 1'b0;
  end
  // released bus shows the inverse, not the last value
  task cmd(input logic [7:0] op);
    @(posedge clk);
    cmd_wr <= 1'b1;
    cmd_data <= op;
    @(posedge clk);
    cmd_wr <= 1'b0;
    cmd_data <= ~op;
  endtask
  task dsel(input logic [7:0] d);
    @(posedge clk);
    dsel_wr <= 1'b1;
    dsel_data <= d;
    @(posedge clk);
    dsel_wr <= 1'b0;
    dsel_data <= ~d;
  endtask
  task set_rst(input logic h, input logic s);
    rst_host <= h;
    rst_soft <= s;
  endtask
endmodule
`default_nettype wire

/* verif/atssr_top_tb.sv */
// self-checking bench for the shadow status bank
`timescale 1ns/100ps
`default_nettype none
module atssr_top_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        fw_rst = 1'b0;
  logic        pkt = 1'b0;
  logic        cpl = 1'b0;
  logic        mcfg = 1'b1;
  logic        pin = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rv;
  logic        pready;
  logic        pslverr;
  logic        re;
  logic        cwr;
  logic        dwr;
  logic        hrst;
  logic        srst;
  logic        shen;
  logic        dae;
  logic [7:0]  cdat;
  logic [7:0]  ddat;
  logic [7:0]  sta;
  logic [7:0]  dsl;
  logic [7:0]  shs;
  logic [7:0]  she;
  int          n_fail = 0;
  int          tests_run = 0;
  int          cyc = 0;
  always #4 clk = ~clk;
  atssr_host_model atssr_host_model_inst (.clk(clk), .cmd_wr(cwr), .cmd_data(cdat),
    .dsel_wr(dwr), .dsel_data(ddat), .rst_host(hrst), .rst_soft(srst));
  atssr_top atssr_top_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .host_reset(hrst), .soft_reset(srst), .firmware_reset(fw_rst),
    .host_cmd_wr(cwr), .host_cmd_data(cdat), .host_dsel_wr(dwr), .host_dsel_data(ddat),
    .auto_packet_active(pkt), .auto_status_active(cpl), .master_drive_config(mcfg),
    .drive_active_pin(pin), .host_status_q(sta), .host_drive_select_q(dsl),
    .host_shadow_status_q(shs), .host_shadow_error_q(she), .shadow_drive_enable_q(shen),
    .drive_active_out_enable_q(dae));
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one apb transfer, index to byte address
  task apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
    wt(2);
  endtask
  task rd(input logic [7:0] idx, input logic [7:0] exp, input string nm);
    apb(1'b0, idx, 8'h00);
    chk(nm, rv, {24'h0, exp});
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      summarize;
    end
  end
  initial
  begin
    wt(4);
    rst <= 1'b0;
    wt(1);
    chk("sta rst", sta, 8'h80);
    rd(8'h36, 8'h00, "dsel rst");
    rd(8'h3f, 8'h00, "sdc rst");
    pin <= 1'b1;
    wt(3);
    rd(8'h3f, 8'h40, "sdc pin");
    chk("shen pin", shen, 1'b1);
    wr(8'h3f, 8'hff);
    pin <= 1'b0;
    wt(3);
    rd(8'h3f, 8'h67, "sdc latch");
    chk("shen latch", shen, 1'b1);
    wr(8'h36, 8'h33);
    atssr_host_model_inst.set_rst(1'b1, 1'b0);
    wt(3);
    chk("dae hr", dae, 1'b1);
    chk("dsl hr", dsl, 8'h00);
    atssr_host_model_inst.set_rst(1'b0, 1'b0);
    wt(4);
    chk("dae after hr", dae, 1'b1);
    rd(8'h3f, 8'h06, "sdc hr");
    wr(8'h3f, 8'h01);
    wt(1);
    chk("dae off", dae, 1'b0);
    wr(8'h36, 8'h33);
    wr(8'h37, 8'h7f);
    atssr_host_model_inst.set_rst(1'b0, 1'b1);
    wt(3);
    chk("dae sr", dae, 1'b0);
    atssr_host_model_inst.set_rst(1'b0, 1'b0);
    wt(4);
    chk("dae after sr", dae, 1'b1);
    chk("sta sr", sta, 8'h90);
    chk("dsl sr", dsl, 8'h00);
    wr(8'h37, 8'h5f);
    chk("sta wr", sta, 8'hdf);
    wr(8'h3c, 8'h01);
    wr(8'h37, 8'hff);
    chk("sta nobsy", sta, 8'h7f);
    wr(8'h36, 8'h10);
    wr(8'h3c, 8'h10);
    chk("sta sig", sta, 8'h10);
    rd(8'h36, 8'h10, "dsel sig");
    wr(8'h38, 8'h01);
    chk("shs set", shs, 8'h01);
    atssr_host_model_inst.cmd(8'ha1);
    wt(3);
    rd(8'h37, 8'ha1, "cmd latch");
    chk("shs cmd", shs, 8'h80);
    wr(8'h39, 8'hff);
    chk("she", she, 8'h04);
    atssr_host_model_inst.dsel(8'h22);
    wr(8'h37, 8'h7f);
    chk("dsl host", dsl, 8'h22);
    atssr_host_model_inst.cmd(8'h90);
    wt(3);
    chk("dsl diag", dsl, 8'h00);
    chk("sta diag", sta, 8'h90);
    wr(8'h3c, 8'h01);
    wr(8'h37, 8'h00);
    wr(8'h3d, 8'h10);
    wr(8'h3e, 8'h45);
    pkt <= 1'b1;
    wt(3);
    chk("sta pkt", sta, 8'h10);
    pkt <= 1'b0;
    cpl <= 1'b1;
    wt(3);
    chk("sta cpl", sta, 8'h45);
    fw_rst <= 1'b1;
    wt(2);
    fw_rst <= 1'b0;
    wt(3);
    chk("cpl fw", {sta[2], sta[0]}, 2'b00);
    cpl <= 1'b0;
    apb(1'b0, 8'h3a, 8'h00);
    chk("err unmapped", re, 1'b1);
    chk("data unmapped", rv, 32'h0);
    summarize;
  end
endmodule
`default_nettype wire
